// ### src/cbr_pkg.sv
package cbr_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_INSTR  = 8'h04;
    localparam logic [7:0] OFF_PC     = 8'h08;
    localparam logic [7:0] OFF_BRIDX  = 8'h0C;
    localparam logic [7:0] OFF_BRMOD  = 8'h10;
    localparam logic [7:0] OFF_DIDX   = 8'h14;
    localparam logic [7:0] OFF_PMOD   = 8'h18;
    localparam logic [7:0] OFF_PCSTK  = 8'h1C;
    localparam logic [7:0] OFF_STSTK  = 8'h20;
    localparam logic [7:0] OFF_ARITHMETIC_STATUS_REGISTER  = 8'h24;
    localparam logic [7:0] OFF_MODE_CONTROL_REGISTER_ONE  = 8'h28;
    localparam logic [7:0] OFF_ILATCH = 8'h2C;
    localparam logic [7:0] OFF_INTERRUPT_MASK_POINTER = 8'h30;
    localparam logic [7:0] OFF_IRQNUM = 8'h34;
    localparam logic [7:0] OFF_LCNT   = 8'h38;
    localparam logic [7:0] OFF_LEND   = 8'h3C;
    localparam logic [7:0] OFF_STATUS = 8'h40;
    localparam logic [7:0] OFF_ADDRX  = 8'h44;
    localparam logic [7:0] OFF_ADDRY  = 8'h48;
    localparam logic [7:0] OFF_DREG   = 8'h4C;
    localparam logic [7:0] OFF_DEPTH  = 8'h50;

    // ==========================================================
    // control bit positions, reset values, responses
    localparam int        CTRL_SIMD   = 0;
    localparam int        CTRL_BC1    = 1;
    localparam int        CTRL_BC9    = 2;
    localparam logic [31:0] RST_ZERO  = 32'h0000_0000;
    localparam logic [31:0] ST_PUSH_MASK = 32'h0000_000F;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLV   = 2'h2;
    localparam logic [1:0] DLY_SLOTS  = 2'h2;
    localparam logic [31:0] LOOP_BACK = 32'h0000_0002;

    // ==========================================================
    // instruction kinds and write-channel states
    typedef enum logic [1:0] {
        CBR_JMP_ELSE = 2'h0,
        CBR_RET_SUB  = 2'h1,
        CBR_RET_INT  = 2'h2,
        CBR_BAD_KIND = 2'h3
    } cbr_kind_t;

    typedef enum logic [3:0] {
        CBR_W_IDLE = 4'b0001,
        CBR_W_ADDR = 4'b0010,
        CBR_W_DATA = 4'b0100,
        CBR_W_RESP = 4'b1000
    } cbr_wstate_t;

    typedef struct packed {
        logic [7:0] spare;
        logic [3:0] dreg;
        logic [5:0] rel_off;
        logic       clear_irq;
        logic       loop_abort;
        logic       mem_write;
        logic       second_dag;
        logic       cond_y;
        logic       cond_x;
        logic       pc_rel;
        logic       loop_reentry;
        logic       delayed;
        logic       compute;
        logic       else_clause;
        logic       cond_present;
        cbr_kind_t  kind;
    } cbr_instr_t;

    typedef struct packed {
        logic lr_skip;
        logic illegal;
        logic st_pop;
        logic bcast;
        logic mem_y;
        logic mem_x;
        logic comp_y;
        logic comp_x;
        logic taken;
    } cbr_stat_t;

endpackage

// ### src/cbr_ctrl.sv
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
// Summary of operation
// - jump-with-else needs both condition and else; only compute may be absent
// - simd jump is taken only when both elements test true
// - each element does else transfer and compute when its own test fails
// - primary uses named data register, secondary the same number with bit 4 set
// - primary addresses with index then post-modifies; secondary uses index plus one
// - else memory access has post-modify only, never pre-modify
// - broadcast bit for the selected dag makes secondary use the same address
// - broadcast read loads one word into both destination registers
// - jump target math is identical in sisd and simd
// - subroutine return pops only the pc stack and branches there
// - interrupt return pops status stack when it was pushed
// - interrupt return clears serviced bit in latch and mask pointer
// - return when condition true or absent; else compute only when false
// - subroutine return takes delay and reentry; interrupt return only delay
// - loop counter decrements at the instruction two before loop end
// - reentry return suppresses the second decrement of that iteration
// - simd return needs both true; plain compute runs where own test true
// - relative offset is six-bit signed; indirect target is index plus modify
// - jump-with-else refuses delay, loop abort and clear interrupt options
module cbr_ctrl #(
    parameter int PC_DEPTH = 8,
    parameter int ST_DEPTH = 4
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    localparam int PW = $clog2(PC_DEPTH);
    localparam int SW = $clog2(ST_DEPTH);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a[7:2] == o[7:2]);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = hit(a, cbr_pkg::OFF_CTRL)   | hit(a, cbr_pkg::OFF_INSTR)
               | hit(a, cbr_pkg::OFF_PC)     | hit(a, cbr_pkg::OFF_BRIDX)
               | hit(a, cbr_pkg::OFF_BRMOD)  | hit(a, cbr_pkg::OFF_DIDX)
               | hit(a, cbr_pkg::OFF_PMOD)   | hit(a, cbr_pkg::OFF_PCSTK)
               | hit(a, cbr_pkg::OFF_STSTK)  | hit(a, cbr_pkg::OFF_ARITHMETIC_STATUS_REGISTER)
               | hit(a, cbr_pkg::OFF_MODE_CONTROL_REGISTER_ONE)  | hit(a, cbr_pkg::OFF_ILATCH)
               | hit(a, cbr_pkg::OFF_INTERRUPT_MASK_POINTER) | hit(a, cbr_pkg::OFF_IRQNUM)
               | hit(a, cbr_pkg::OFF_LCNT)   | hit(a, cbr_pkg::OFF_LEND);
    endfunction

    // ==========================================================
    // state
    cbr_pkg::cbr_wstate_t wst;
    logic [7:0]   aw_addr;
    logic [31:0]  w_data;
    logic [2:0]   ctrl;
    logic [31:0]  pc, bridx, brmod, didx, pmod;
    logic [31:0]  arithmetic_status_register, mode_control_register_one, ilatch, interrupt_mask_pointer, lcnt, lend;
    logic [4:0]   irq_num;
    logic [31:0]  addr_x, addr_y;
    logic [4:0]   dreg_x, dreg_y;
    cbr_pkg::cbr_stat_t stat;
    logic         lr_skip;
    logic [1:0]   dly_cnt;
    logic [31:0]  dly_tgt;
    logic [31:0]  pc_stk [PC_DEPTH];
    logic [31:0]  as_stk [ST_DEPTH];
    logic [31:0]  m1_stk [ST_DEPTH];
    logic [PW:0]  pc_sp;
    logic [SW:0]  st_sp;

    // ==========================================================
    // bus decode
    wire aw_fire  = s_axi_awvalid & s_axi_awready;
    wire w_fire   = s_axi_wvalid & s_axi_wready;
    wire do_write = (wst == cbr_pkg::CBR_W_ADDR) & w_fire
                  | (wst == cbr_pkg::CBR_W_DATA) & aw_fire
                  | (wst == cbr_pkg::CBR_W_IDLE) & aw_fire & w_fire;
    wire [7:0]  wa = (wst == cbr_pkg::CBR_W_ADDR) ? aw_addr : s_axi_awaddr;
    wire [31:0] wd = (wst == cbr_pkg::CBR_W_DATA) ? w_data : s_axi_wdata;
    wire full_w   = (s_axi_wstrb == 4'hF);
    wire w_ok     = mapped(wa);
    wire wr_en    = do_write & w_ok;
    wire exec     = wr_en & hit(wa, cbr_pkg::OFF_INSTR);

    // ==========================================================
    // instruction decode
    cbr_pkg::cbr_instr_t ins;
    assign ins = cbr_pkg::cbr_instr_t'(wd);
    wire simd   = ctrl[cbr_pkg::CTRL_SIMD];
    wire is_jmp = (ins.kind == cbr_pkg::CBR_JMP_ELSE);
    wire is_rts = (ins.kind == cbr_pkg::CBR_RET_SUB);
    wire is_rti = (ins.kind == cbr_pkg::CBR_RET_INT);
    wire is_ret = is_rts | is_rti;
    wire st_empty = (pc_sp == '0);
    wire bad_jmp = is_jmp & (~ins.cond_present | ~ins.else_clause
                 | ins.delayed | ins.loop_abort | ins.clear_irq
                 | ins.loop_reentry);
    wire bad_ret = is_ret & (ins.loop_abort | ins.clear_irq
                 | ins.else_clause & ~ins.cond_present)
                 | is_rti & ins.loop_reentry;
    wire illegal = bad_jmp | bad_ret | (ins.kind == cbr_pkg::CBR_BAD_KIND);
    wire cond_t  = ~ins.cond_present
                 | ins.cond_x & (~simd | ins.cond_y);
    wire fail_x  = ins.cond_present & ~ins.cond_x;
    wire fail_y  = simd & ins.cond_present & ~ins.cond_y;
    wire pass_x  = ~ins.cond_present | ins.cond_x;
    wire pass_y  = simd & (~ins.cond_present | ins.cond_y);
    wire comp_x  = ins.compute & (ins.else_clause ? fail_x : pass_x);
    wire comp_y  = ins.compute & (ins.else_clause ? fail_y : pass_y);
    wire mem_x   = is_jmp & fail_x;
    wire mem_y   = is_jmp & fail_y;
    wire bcast   = ins.second_dag ? ctrl[cbr_pkg::CTRL_BC9]
                                  : ctrl[cbr_pkg::CTRL_BC1];
    wire ret_ok  = is_ret & ~st_empty;
    wire taken   = cond_t & (is_jmp | ret_ok);
    wire run     = exec & ~illegal & ~(is_ret & cond_t & st_empty);
    wire [31:0] rel   = {{26{ins.rel_off[5]}}, ins.rel_off};
    wire [31:0] j_tgt = ins.pc_rel ? pc + rel : bridx + brmod;
    wire [31:0] top   = pc_stk[PW'(pc_sp - 1'b1)];
    wire [31:0] tgt   = is_jmp ? j_tgt : top;
    wire [31:0] pc_inc = pc + 32'h1;
    wire [31:0] nxt_seq = (dly_cnt == 2'h1) ? dly_tgt : pc_inc;
    wire take_now = taken & ~ins.delayed;
    wire [31:0] next_pc = take_now ? tgt : nxt_seq;
    wire [31:0] dec_pc  = lend - cbr_pkg::LOOP_BACK;
    wire at_dec  = (lcnt != '0) & (pc == dec_pc);
    wire lr_hit  = taken & is_rts & ins.loop_reentry
                 & (top >= dec_pc) & (top <= lend);
    wire pop_st  = taken & is_rti & cbr_pkg::ST_PUSH_MASK[irq_num]
                 & (st_sp != '0);
    wire [31:0] irq_bit = 32'h1 << irq_num;
    wire mem_any = mem_x | mem_y;

    // ==========================================================
    // write channel state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst           <= cbr_pkg::CBR_W_IDLE;
            aw_addr       <= '0;
            w_data        <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= cbr_pkg::RESP_OKAY;
        end else begin
            case (wst)
                cbr_pkg::CBR_W_IDLE: begin
                    s_axi_awready <= 1'b1;
                    s_axi_wready  <= 1'b1;
                    if (aw_fire & ~w_fire) begin
                        wst           <= cbr_pkg::CBR_W_ADDR;
                        aw_addr       <= s_axi_awaddr;
                        s_axi_awready <= 1'b0;
                    end else if (w_fire & ~aw_fire) begin
                        wst          <= cbr_pkg::CBR_W_DATA;
                        w_data       <= s_axi_wdata;
                        s_axi_wready <= 1'b0;
                    end
                end
                cbr_pkg::CBR_W_ADDR, cbr_pkg::CBR_W_DATA: begin
                end
                cbr_pkg::CBR_W_RESP: begin
                    if (s_axi_bready) begin
                        wst           <= cbr_pkg::CBR_W_IDLE;
                        s_axi_bvalid  <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready  <= 1'b1;
                    end
                end
                default: wst <= cbr_pkg::CBR_W_IDLE;
            endcase
            if (do_write) begin
                wst           <= cbr_pkg::CBR_W_RESP;
                s_axi_awready <= 1'b0;
                s_axi_wready  <= 1'b0;
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= (w_ok & full_w) ? cbr_pkg::RESP_OKAY
                                                 : cbr_pkg::RESP_SLV;
            end
        end
    end

    // ==========================================================
    // sequencer registers
    wire we = wr_en & full_w;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= '0;  pc <= '0;  bridx <= '0;  brmod <= '0;
            didx <= '0;  pmod <= '0;  arithmetic_status_register <= '0;  mode_control_register_one <= '0;
            ilatch <= '0;  interrupt_mask_pointer <= '0;  irq_num <= '0;
            lcnt <= '0;  lend <= '0;  pc_sp <= '0;  st_sp <= '0;
            addr_x <= '0;  addr_y <= '0;  dreg_x <= '0;  dreg_y <= '0;
            stat <= '0;  lr_skip <= 1'b0;  dly_cnt <= '0;  dly_tgt <= '0;
        end else if (we) begin
            if (hit(wa, cbr_pkg::OFF_CTRL))   ctrl   <= wd[2:0];
            if (hit(wa, cbr_pkg::OFF_PC))     pc     <= wd;
            if (hit(wa, cbr_pkg::OFF_BRIDX))  bridx  <= wd;
            if (hit(wa, cbr_pkg::OFF_BRMOD))  brmod  <= wd;
            if (hit(wa, cbr_pkg::OFF_DIDX))   didx   <= wd;
            if (hit(wa, cbr_pkg::OFF_PMOD))   pmod   <= wd;
            if (hit(wa, cbr_pkg::OFF_ARITHMETIC_STATUS_REGISTER))  arithmetic_status_register  <= wd;
            if (hit(wa, cbr_pkg::OFF_MODE_CONTROL_REGISTER_ONE))  mode_control_register_one  <= wd;
            if (hit(wa, cbr_pkg::OFF_ILATCH)) ilatch <= wd;
            if (hit(wa, cbr_pkg::OFF_INTERRUPT_MASK_POINTER)) interrupt_mask_pointer <= wd;
            if (hit(wa, cbr_pkg::OFF_IRQNUM)) irq_num <= wd[4:0];
            if (hit(wa, cbr_pkg::OFF_LCNT))   lcnt   <= wd;
            if (hit(wa, cbr_pkg::OFF_LEND))   lend   <= wd;
            if (hit(wa, cbr_pkg::OFF_PCSTK) && pc_sp != (PW+1)'(PC_DEPTH)) begin
                pc_stk[pc_sp[PW-1:0]] <= wd;
                pc_sp <= pc_sp + 1'b1;
            end
            if (hit(wa, cbr_pkg::OFF_STSTK) && st_sp != (SW+1)'(ST_DEPTH)) begin
                as_stk[st_sp[SW-1:0]] <= arithmetic_status_register;
                m1_stk[st_sp[SW-1:0]] <= mode_control_register_one;
                st_sp <= st_sp + 1'b1;
            end
            if (exec) begin
                stat <= '{lr_skip: lr_skip, illegal: ~run, st_pop: run & pop_st,
                          bcast: run & mem_any & bcast & ~ins.mem_write,
                          mem_y: run & mem_y, mem_x: run & mem_x,
                          comp_y: run & comp_y, comp_x: run & comp_x,
                          taken: run & taken};
            end
            if (run) begin
                pc <= next_pc;
                if (dly_cnt != '0) dly_cnt <= dly_cnt - 2'h1;
                if (taken & ins.delayed) begin
                    dly_cnt <= cbr_pkg::DLY_SLOTS;
                    dly_tgt <= tgt;
                end
                if (mem_any) begin
                    addr_x <= didx;
                    addr_y <= bcast ? didx : didx + 32'h1;
                    didx   <= didx + pmod;
                    dreg_x <= {1'b0, ins.dreg};
                    dreg_y <= {1'b1, ins.dreg};
                end
                if (taken & is_ret)
                    pc_sp <= pc_sp - 1'b1;
                if (pop_st) begin
                    arithmetic_status_register <= as_stk[SW'(st_sp - 1'b1)];
                    mode_control_register_one <= m1_stk[SW'(st_sp - 1'b1)];
                    st_sp <= st_sp - 1'b1;
                end
                if (taken & is_rti) begin
                    ilatch <= ilatch & ~irq_bit;
                    interrupt_mask_pointer <= interrupt_mask_pointer & ~irq_bit;
                end
                if (at_dec & ~lr_skip)
                    lcnt <= lcnt - 32'h1;
                if (at_dec)
                    lr_skip <= 1'b0;
                if (lr_hit)
                    lr_skip <= 1'b1;
            end
        end
    end

    // ==========================================================
    // read channel
    wire [7:0] ra = s_axi_araddr;
    wire r_ok = mapped(ra)
              | hit(ra, cbr_pkg::OFF_STATUS) | hit(ra, cbr_pkg::OFF_ADDRX)
              | hit(ra, cbr_pkg::OFF_ADDRY)  | hit(ra, cbr_pkg::OFF_DREG)
              | hit(ra, cbr_pkg::OFF_DEPTH);
    wire [31:0] r_word =
        hit(ra, cbr_pkg::OFF_CTRL)   ? {29'h0, ctrl} :
        hit(ra, cbr_pkg::OFF_PC)     ? pc :
        hit(ra, cbr_pkg::OFF_BRIDX)  ? bridx :
        hit(ra, cbr_pkg::OFF_BRMOD)  ? brmod :
        hit(ra, cbr_pkg::OFF_DIDX)   ? didx :
        hit(ra, cbr_pkg::OFF_PMOD)   ? pmod :
        hit(ra, cbr_pkg::OFF_PCSTK)  ? (st_empty ? 32'h0 : top) :
        hit(ra, cbr_pkg::OFF_ARITHMETIC_STATUS_REGISTER)  ? arithmetic_status_register :
        hit(ra, cbr_pkg::OFF_MODE_CONTROL_REGISTER_ONE)  ? mode_control_register_one :
        hit(ra, cbr_pkg::OFF_ILATCH) ? ilatch :
        hit(ra, cbr_pkg::OFF_INTERRUPT_MASK_POINTER) ? interrupt_mask_pointer :
        hit(ra, cbr_pkg::OFF_IRQNUM) ? {27'h0, irq_num} :
        hit(ra, cbr_pkg::OFF_LCNT)   ? lcnt :
        hit(ra, cbr_pkg::OFF_LEND)   ? lend :
        hit(ra, cbr_pkg::OFF_STATUS) ? {21'h0, dly_cnt, stat} :
        hit(ra, cbr_pkg::OFF_ADDRX)  ? addr_x :
        hit(ra, cbr_pkg::OFF_ADDRY)  ? addr_y :
        hit(ra, cbr_pkg::OFF_DREG)   ? {19'h0, dreg_y, 3'h0, dreg_x} :
        hit(ra, cbr_pkg::OFF_DEPTH)  ? {16'h0, 8'(st_sp), 8'(pc_sp)} :
        cbr_pkg::RST_ZERO;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= cbr_pkg::RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= r_word;
            s_axi_rresp   <= r_ok ? cbr_pkg::RESP_OKAY : cbr_pkg::RESP_SLV;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_jump_needs_both: assert property (exec & ~illegal & is_jmp & simd
        & ~(ins.cond_x & ins.cond_y) |=> ~stat.taken & pc == $past(pc_inc))
        else $error("simd jump taken without both conditions");
    a_else_per_pe: assert property (run & is_jmp & simd
        |=> stat.mem_x == $past(fail_x) && stat.mem_y == $past(fail_y))
        else $error("else transfer not per element");
    a_post_modify: assert property (run & mem_any
        |=> didx == $past(didx) + $past(pmod) && addr_x == $past(didx))
        else $error("index not post-modified");
    a_addr_y_step: assert property (run & mem_any
        |=> addr_y == $past(didx) + ($past(bcast) ? 32'h0 : 32'h1))
        else $error("secondary address wrong");
    a_indirect_tgt: assert property (run & is_jmp & taken & ~ins.pc_rel
        & dly_cnt == 2'h0 |=> pc == $past(bridx) + $past(brmod) && bridx == $past(bridx))
        else $error("indirect target wrong");
    a_jump_opts_bad: assert property (exec & is_jmp & (ins.delayed | ins.loop_abort
        | ins.clear_irq) |=> stat.illegal && pc == $past(pc))
        else $error("forbidden jump option accepted");
    a_rts_stacks: assert property (run & is_rts & taken
        |=> st_sp == $past(st_sp) && pc_sp == $past(pc_sp) - 1'b1)
        else $error("subroutine return touched status stack");
    a_rti_clear: assert property (run & is_rti & taken
        |=> ilatch[$past(irq_num)] == 1'b0 && interrupt_mask_pointer[$past(irq_num)] == 1'b0)
        else $error("interrupt bit not cleared");
    a_loop_dec: assert property (run & at_dec & ~lr_skip
        |=> lcnt == $past(lcnt) - 32'h1)
        else $error("loop counter not decremented");
    a_lr_no_dec: assert property (run & at_dec & lr_skip
        |=> lcnt == $past(lcnt) && ~lr_skip)
        else $error("second decrement not suppressed");

    c_jump_else: cover property (run & is_jmp & mem_x & simd);
    c_rti_pop: cover property (run & pop_st);
    c_lr_skip: cover property (run & at_dec & lr_skip);
    c_delayed: cover property (run & taken & ins.delayed ##1 dly_cnt == 2'h2);

endmodule

// ### test/cbr_prog.sv
`timescale 1ns/10ps
// ==========
// program words offered to the sequencer
module cbr_prog (
    output logic [31:0] code [12]
);
    always_comb begin
        code[0] = 32'h0030011C;
        code[1] = 32'h0000000C;
        code[2] = 32'h0000030C;
        code[3] = 32'h0000002C;
        code[4] = 32'h00000004;
        code[5] = 32'h00000002;
        code[6] = 32'h0000001D;
        code[7] = 32'h00000042;
        code[8] = 32'h000F838C;
        code[9] = 32'h00000041;
        code[10] = 32'h00000001;
        code[11] = 32'h00000021;
    end
endmodule

// ### test/cbr_ctrl_bench.sv
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module cbr_ctrl_bench;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, got;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp, gresp;
    logic [31:0] code [12];
    int          n_errors = 0, n_checks = 0;
    always #4 aclk = ~aclk;
    cbr_prog cbr_prog_inst (.code(code));
    cbr_ctrl cbr_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    // ==========
    // bus cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        gresp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        got = rdata; gresp = rresp;
        rready <= 1'b0;
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ==========
    // scenarios
    task automatic t_regs;
        rd(cbr_pkg::OFF_CTRL); `CHK(got, cbr_pkg::RST_ZERO)
        rd(8'h7C); `CHK(gresp, cbr_pkg::RESP_SLV)
    endtask
    task automatic t_jump;
        wr(cbr_pkg::OFF_CTRL, 32'h1); wr(cbr_pkg::OFF_DIDX, 32'h10);
        wr(cbr_pkg::OFF_PMOD, 32'h4); wr(cbr_pkg::OFF_INSTR, code[0]);
        `CHK(gresp, cbr_pkg::RESP_OKAY)
        rd(cbr_pkg::OFF_STATUS); `CHK(got, 32'h14)
        rd(cbr_pkg::OFF_ADDRY); `CHK(got, 32'h11)
        rd(cbr_pkg::OFF_DIDX); `CHK(got, 32'h14)
        rd(cbr_pkg::OFF_DREG); `CHK(got, 32'h1303)
        wr(cbr_pkg::OFF_CTRL, 32'h3); wr(cbr_pkg::OFF_INSTR, code[1]);
        rd(cbr_pkg::OFF_STATUS); `CHK(got, 32'h38)
        rd(cbr_pkg::OFF_ADDRY); `CHK(got, 32'h14)
        wr(cbr_pkg::OFF_BRIDX, 32'h20); wr(cbr_pkg::OFF_BRMOD, 32'h8);
        wr(cbr_pkg::OFF_INSTR, code[2]);
        rd(cbr_pkg::OFF_STATUS); `CHK(got, 32'h1)
        rd(cbr_pkg::OFF_PC); `CHK(got, 32'h28)
        rd(cbr_pkg::OFF_BRIDX); `CHK(got, 32'h20)
        wr(cbr_pkg::OFF_INSTR, code[8]);
        rd(cbr_pkg::OFF_PC); `CHK(got, 32'h26)
        wr(cbr_pkg::OFF_INSTR, code[3]);
        rd(cbr_pkg::OFF_STATUS); `CHK(got, 32'h80)
        wr(cbr_pkg::OFF_INSTR, code[4]);
        rd(cbr_pkg::OFF_STATUS); `CHK(got, 32'h80)
    endtask
    task automatic t_ret;
        wr(cbr_pkg::OFF_CTRL, 32'h0); wr(cbr_pkg::OFF_PCSTK, 32'h55);
        wr(cbr_pkg::OFF_IRQNUM, 32'h2); wr(cbr_pkg::OFF_ILATCH, 32'h4);
        wr(cbr_pkg::OFF_INTERRUPT_MASK_POINTER, 32'h4); wr(cbr_pkg::OFF_STSTK, 32'h0);
        wr(cbr_pkg::OFF_INSTR, code[5]);
        rd(cbr_pkg::OFF_STATUS); `CHK(got, 32'h41)
        rd(cbr_pkg::OFF_PC); `CHK(got, 32'h55)
        rd(cbr_pkg::OFF_ILATCH); `CHK(got, 32'h0)
        rd(cbr_pkg::OFF_INTERRUPT_MASK_POINTER); `CHK(got, 32'h0)
        wr(cbr_pkg::OFF_PCSTK, 32'h66); wr(cbr_pkg::OFF_INSTR, code[6]);
        rd(cbr_pkg::OFF_STATUS); `CHK(got, 32'h2)
        rd(cbr_pkg::OFF_DEPTH); `CHK(got, 32'h1)
    endtask
    task automatic t_loop;
        wr(cbr_pkg::OFF_LEND, 32'h30); wr(cbr_pkg::OFF_LCNT, 32'h5);
        wr(cbr_pkg::OFF_PC, 32'h2E); wr(cbr_pkg::OFF_PCSTK, 32'h2F);
        wr(cbr_pkg::OFF_INSTR, code[9]);
        rd(cbr_pkg::OFF_LCNT); `CHK(got, 32'h4)
        wr(cbr_pkg::OFF_PC, 32'h2E); wr(cbr_pkg::OFF_PCSTK, 32'h40);
        wr(cbr_pkg::OFF_INSTR, code[10]);
        rd(cbr_pkg::OFF_STATUS); `CHK(got, 32'h101)
        rd(cbr_pkg::OFF_LCNT); `CHK(got, 32'h4)
        wr(cbr_pkg::OFF_PCSTK, 32'h70); wr(cbr_pkg::OFF_INSTR, code[11]);
        rd(cbr_pkg::OFF_STATUS); `CHK(got, 32'h401)
        rd(cbr_pkg::OFF_PC); `CHK(got, 32'h41)
        wr(cbr_pkg::OFF_INSTR, code[7]);
        rd(cbr_pkg::OFF_STATUS); `CHK(got, 32'h480)
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_jump();
        t_ret();
        t_loop();
        end_sim();
    end
    initial begin
        repeat (5000) @(posedge aclk);
        n_errors++;
        end_sim();
    end
endmodule
